// ---- svm_consts.svh ----
// Register offsets, bit positions, reset values and timing counts of the supply monitor.
`ifndef SVM_CONSTS_SVH
`define SVM_CONSTS_SVH

// Register offsets on the 8-bit register port.
`define SVM_ADDR_DETECT_EN   8'h00
`define SVM_ADDR_THRESHOLD   8'h01
`define SVM_ADDR_CTRL1       8'h02
`define SVM_ADDR_CTRL2       8'h03
`define SVM_ADDR_STATUS1     8'h04
`define SVM_ADDR_COND2       8'h05
`define SVM_ADDR_STATUS2     8'h06
`define SVM_ADDR_IRQ_STATUS  8'h08
`define SVM_ADDR_IRQ_CLEAR   8'h09
`define SVM_ADDR_IRQ_ENABLE  8'h0A

// Bit positions inside the flag status registers.
`define SVM_STAT_PASSAGE_BIT 0
`define SVM_STAT_LEVEL_BIT   1

// Reset values of the software registers.
`define SVM_RST_DETECT_EN    2'h0
`define SVM_RST_THRESHOLD    8'h44
`define SVM_RST_CTRL         8'h00
`define SVM_RST_COND2        2'h0
`define SVM_RST_IRQ_ENABLE   2'h0

// Release delay after the supply recovers, and the clock period it is counted in.
`define SVM_RELEASE_TIME_NS  100000
`define SVM_CLK_PERIOD_NS    50

`endif

// ---- svm_pkg.sv ----
// Types shared by the supply monitor control logic.
package svm_pkg;

  // Per-channel control register layout, most significant bit first.
  typedef struct packed {
    logic       release_select;      // 1: release at the crossing, 0: after the delay.
    logic       action_mode;         // 1: reset action, 0: interrupt action.
    logic [1:0] sample_divider;      // Sampling clock divide select.
    logic       reserved;            // Reads as zero.
    logic       compare_out_enable;  // Passes the comparator result onward.
    logic       filter_bypass;       // Skips the sampling filter.
    logic       action_enable;       // Allows the selected action.
  } svm_ch_ctrl_t;

  // Crossing kinds selectable for channel 2.
  typedef enum logic [1:0] {
    SVM_COND_RISE = 2'b00,
    SVM_COND_FALL = 2'b01,
    SVM_COND_BOTH = 2'b10,
    SVM_COND_ANY  = 2'b11
  } svm_cond_t;

endpackage : svm_pkg

// ---- svm_supply_monitor.sv ----
// Control logic of a three-channel supply voltage monitor with register port.
//
// Summary of operation
// - Channel 0 resets below threshold, delayed release.
// - Channel 0 level from option word field.
// - Channels 1, 2 detect rising and falling crossings.
// - Read-only level flag shows current supply side.
// - Passage flag latches on configured crossing.
// - Reset mode: release after delay or crossing.
// - Mode bit picks action; enable bit gates it.
// - Filter bypass bit skips the sampling filter.
// - Sample clock is slow oscillator over 2..16.
// - Channel 1 level code in low nibble.
// - Channel 2 level code in high nibble.
// - Compare output enable gates result to logic.
// - Common register holds both detection enables.
// - Channel 2 condition picks rise, fall, both.
// - Channel 2 passage emits a link event.
//
// Channel 0 is always armed.
// It holds the reset request from reset on.
// A dip restarts its release count.
// Channels 1 and 2 share one structure.
// Each has a divider, filter and reset timer.
// Dividers count oscillator edges.
// They run free, so a first tick may be early.
// Filtering needs two agreeing ticks.
// The accepted level feeds flag, edges, hold.
// A closed gate freezes the accepted level.
// Reopening it may show one late crossing.
// So configure a channel before enabling it.
// Interrupts need interrupt mode and enable.
// Resets need reset mode, enable, detection.
// A set wins a clear in the same cycle.
// Invalid level codes are passed unchecked.
// Comparator syncs reset to above.
// So no false drop follows reset.
// The oscillator sync resets low.
// The link event trails a crossing by one.
// Read data are zero outside the answer.
// Unmapped offsets read zero.
// Writes to them are ignored.
// The reserved control bit reads zero.
// The channel 0 field is caught once.
// Delays count system cycles.
// Twelve counter bits cover the delay.
// Channel 1 reports every crossing.
// Channel 2 obeys its condition field.
// Passage flags clear on a written zero.
// Status clears on a written one.
// Irq stays high while enabled bits stand.
`timescale 1ns/1ps
`default_nettype none
`include "svm_consts.svh"

module svm_supply_monitor
  import svm_pkg::*;
(
  input  wire logic       clk,                    // System clock, 20 MHz.
  input  wire logic       rst_n,                  // Synchronous reset, active low.
  input  wire logic [7:0] reg_addr,               // Register address.
  input  wire logic [7:0] reg_wdata,              // Register write data.
  input  wire logic       reg_wr,                 // Write strobe.
  input  wire logic       reg_rd,                 // Read strobe.
  output logic      [7:0] reg_rdata,              // Read data, one cycle after the strobe.
  input  wire logic [1:0] option_word_one,        // Channel 0 level field of option memory.
  input  wire logic       slow_onchip_oscillator, // Slow oscillator, asynchronous.
  input  wire logic       ch0_above,              // Comparator 0: supply above threshold.
  input  wire logic       ch1_above,              // Comparator 1: supply above threshold.
  input  wire logic       ch2_above,              // Comparator 2: supply above threshold.
  output logic      [1:0] ch0_threshold_code,     // Channel 0 level select to the analog part.
  output logic      [3:0] ch1_threshold_code,     // Channel 1 level select to the analog part.
  output logic      [3:0] ch2_threshold_code,     // Channel 2 level select to the analog part.
  output logic      [1:0] detect_on,              // Comparator power enables, channel 1 in bit 0.
  output logic            supply_reset_req,       // Reset request to the reset logic.
  output logic            irq,                    // Level interrupt.
  output logic            ch2_passage_event       // One-cycle event to the link logic.
);

  // Release delay in clock cycles, rounded up.
  localparam int RELEASE_CYC_I =
    (`SVM_RELEASE_TIME_NS + `SVM_CLK_PERIOD_NS - 1) / `SVM_CLK_PERIOD_NS;
  localparam logic [11:0] RELEASE_LAST = 12'(RELEASE_CYC_I - 1);

  // Software registers.
  logic [1:0]   detect_on_r;    // Detection enables, channel 1 in bit 0.
  logic [7:0]   threshold_r;    // Level codes of channels 1 and 2.
  svm_ch_ctrl_t ctrl_r [2];     // Control registers of channels 1 and 2.
  logic [1:0]   cond2_r;        // Channel 2 crossing condition.
  logic [1:0]   passage_r;      // Passage flags, channel 1 in bit 0.
  logic [1:0]   irq_status_r;   // Sticky interrupt events.
  logic [1:0]   irq_enable_r;   // Interrupt enables.
  logic [1:0]   ch0_code_r;     // Captured option word field.
  logic         strap_taken_r;  // Option field has been captured.
  logic [7:0]   rdata_r;        // Registered read data.
  logic [7:0]   rdata_nxt;      // Read data selected this cycle.
  logic         event_r;        // Registered link event.

  // Synchronisers for the asynchronous inputs.
  logic [2:0] cmp_meta_r;       // First stage, read only by the second stage.
  logic [2:0] cmp_sync_r;       // Synchronised comparator levels.
  logic       osc_meta_r;       // First stage of the slow oscillator.
  logic       osc_sync_r;       // Synchronised slow oscillator.
  logic       osc_prev_r;       // Previous synchronised oscillator level.
  logic       osc_rise;         // One-cycle pulse on each oscillator rising edge.

  // Per-channel results collected from the channel loop.
  logic [1:0] lvl_w;            // Filtered level, 1 while supply is above.
  logic [1:0] cross_w;          // Crossing of the configured kind this cycle.
  logic [1:0] rst_w;            // Reset request of the channel.
  logic [1:0] irq_ev_w;         // Interrupt event of the channel.

  // Channel 0 reset timing.
  logic        ch0_hold_r;      // Channel 0 is holding the reset.
  logic [11:0] ch0_cnt_r;       // Channel 0 release counter.

  // Comparator inputs pass two flip-flops before anything reads them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_meta_r <= 3'h7;
      cmp_sync_r <= 3'h7;
    end else begin
      cmp_meta_r <= {ch2_above, ch1_above, ch0_above};
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // The slow oscillator is synchronised and its rising edge becomes an enable pulse.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_meta_r <= slow_onchip_oscillator;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  assign osc_rise = osc_sync_r & ~osc_prev_r;

  // The option field is caught once, in the first cycle after reset release.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch0_code_r    <= 2'h0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      ch0_code_r    <= option_word_one;
      strap_taken_r <= 1'b1;
    end
  end

  // Channel 0 holds reset while below, then counts the delay once above.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch0_hold_r <= 1'b1;
      ch0_cnt_r  <= 12'h000;
    end else if (!cmp_sync_r[0]) begin
      ch0_hold_r <= 1'b1;
      ch0_cnt_r  <= 12'h000;
    end else if (ch0_hold_r) begin
      // A dip during the count restarts it, so release needs a steady interval.
      if (ch0_cnt_r == RELEASE_LAST) begin
        ch0_hold_r <= 1'b0;
      end else begin
        ch0_cnt_r <= ch0_cnt_r + 12'h001;
      end
    end
  end

  // Channels 1 and 2 share one structure: divider, filter, crossing and reset timing.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      logic [3:0]  div_cnt_r;   // Counts oscillator edges for the sample clock.
      logic [3:0]  div_mask;    // Low counter bits that must all be set for a tick.
      logic        tick;        // Sample enable pulse.
      logic        gate;        // Comparator result allowed through.
      logic        smp_r;       // Previous filter sample.
      logic        lvl_r;       // Accepted level.
      logic        prev_r;      // Accepted level one cycle earlier.
      logic        rise;        // Supply went above the threshold.
      logic        fall;        // Supply went below the threshold.
      logic        hold_r;      // Channel is holding its reset.
      logic [11:0] cnt_r;       // Release delay counter.

      assign gate = detect_on_r[gi] & ctrl_r[gi].compare_out_enable;

      // Divide select 0..3 gives a tick every 2, 4, 8 or 16 oscillator edges.
      assign div_mask = {ctrl_r[gi].sample_divider == 2'h3,
                         ctrl_r[gi].sample_divider[1],
                         ctrl_r[gi].sample_divider != 2'h0,
                         1'b1};
      assign tick     = osc_rise & ((div_cnt_r & div_mask) == div_mask);

      // Free-running divider of the slow oscillator edges.
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          div_cnt_r <= 4'h0;
        end else if (osc_rise) begin
          div_cnt_r <= div_cnt_r + 4'h1;
        end
      end

      // Filter: a new level is taken when two consecutive samples agree.
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          smp_r <= 1'b1;
          lvl_r <= 1'b1;
        end else if (gate) begin
          if (ctrl_r[gi].filter_bypass) begin
            // Bypass follows the comparator directly.
            smp_r <= cmp_sync_r[gi+1];
            lvl_r <= cmp_sync_r[gi+1];
          end else if (tick) begin
            smp_r <= cmp_sync_r[gi+1];
            if (smp_r == cmp_sync_r[gi+1]) begin
              lvl_r <= cmp_sync_r[gi+1];
            end
          end
        end
      end

      // Edge detection on the accepted level.
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          prev_r <= 1'b1;
        end else begin
          prev_r <= lvl_r;
        end
      end

      assign rise = lvl_r & ~prev_r;
      assign fall = ~lvl_r & prev_r;

      // Channel 1 reports any crossing; channel 2 follows its condition field.
      if (gi == 0) begin : g_any
        assign cross_w[gi] = gate & (rise | fall);
      end else begin : g_cond
        // Rise, fall, or both for the two remaining codes.
        assign cross_w[gi] = gate & ((svm_cond_t'(cond2_r) == SVM_COND_RISE) ? rise :
                                     (svm_cond_t'(cond2_r) == SVM_COND_FALL) ? fall :
                                     (rise | fall));
      end

      // Reset timing: hold while below, release at the crossing or after the delay.
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          hold_r <= 1'b0;
          cnt_r  <= 12'h000;
        end else if (!lvl_r) begin
          hold_r <= 1'b1;
          cnt_r  <= 12'h000;
        end else if (hold_r) begin
          if (ctrl_r[gi].release_select || cnt_r == RELEASE_LAST) begin
            hold_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r + 12'h001;
          end
        end
      end

      assign lvl_w[gi]    = lvl_r;
      // The mode bit picks the action and the enable bit lets it out.
      assign rst_w[gi]    = hold_r & detect_on_r[gi] & ctrl_r[gi].action_mode
                            & ctrl_r[gi].action_enable;
      assign irq_ev_w[gi] = cross_w[gi] & ~ctrl_r[gi].action_mode
                            & ctrl_r[gi].action_enable;
    end
  endgenerate

  // Configuration registers written by software.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      detect_on_r  <= `SVM_RST_DETECT_EN;
      threshold_r  <= `SVM_RST_THRESHOLD;
      ctrl_r[0]    <= svm_ch_ctrl_t'(`SVM_RST_CTRL);
      ctrl_r[1]    <= svm_ch_ctrl_t'(`SVM_RST_CTRL);
      cond2_r      <= `SVM_RST_COND2;
      irq_enable_r <= `SVM_RST_IRQ_ENABLE;
    end else if (reg_wr) begin
      case (reg_addr)
        `SVM_ADDR_DETECT_EN: detect_on_r  <= reg_wdata[1:0];
        `SVM_ADDR_THRESHOLD: threshold_r  <= reg_wdata;
        `SVM_ADDR_CTRL1:     ctrl_r[0]    <= svm_ch_ctrl_t'(reg_wdata & 8'hF7);
        `SVM_ADDR_CTRL2:     ctrl_r[1]    <= svm_ch_ctrl_t'(reg_wdata & 8'hF7);
        `SVM_ADDR_COND2:     cond2_r      <= reg_wdata[1:0];
        `SVM_ADDR_IRQ_ENABLE: irq_enable_r <= reg_wdata[1:0];
        default: begin
          // Other offsets hold no writable configuration.
        end
      endcase
    end
  end

  // Passage flags: set on a crossing, cleared by writing zero; a set wins the clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      passage_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cross_w[i]) begin
          passage_r[i] <= 1'b1;
        end else if (reg_wr && !reg_wdata[`SVM_STAT_PASSAGE_BIT] &&
                     reg_addr == (i == 0 ? `SVM_ADDR_STATUS1 : `SVM_ADDR_STATUS2)) begin
          passage_r[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky interrupt status, cleared by writing one to the clear register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (irq_ev_w[i]) begin
          irq_status_r[i] <= 1'b1;
        end else if (reg_wr && reg_addr == `SVM_ADDR_IRQ_CLEAR && reg_wdata[i]) begin
          irq_status_r[i] <= 1'b0;
        end
      end
    end
  end

  // Channel 2 crossings leave as a one-cycle event to the link logic.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_r <= 1'b0;
    end else begin
      event_r <= cross_w[1];
    end
  end

  // Read data selection; unmapped and write-only offsets read zero.
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `SVM_ADDR_DETECT_EN:  rdata_nxt = {6'h00, detect_on_r};
      `SVM_ADDR_THRESHOLD:  rdata_nxt = threshold_r;
      `SVM_ADDR_CTRL1:      rdata_nxt = ctrl_r[0];
      `SVM_ADDR_CTRL2:      rdata_nxt = ctrl_r[1];
      `SVM_ADDR_STATUS1:    rdata_nxt = {6'h00, lvl_w[0], passage_r[0]};
      `SVM_ADDR_COND2:      rdata_nxt = {6'h00, cond2_r};
      `SVM_ADDR_STATUS2:    rdata_nxt = {6'h00, lvl_w[1], passage_r[1]};
      `SVM_ADDR_IRQ_STATUS: rdata_nxt = {6'h00, irq_status_r};
      `SVM_ADDR_IRQ_ENABLE: rdata_nxt = {6'h00, irq_enable_r};
      default:              rdata_nxt = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  // Outputs.
  assign reg_rdata          = rdata_r;
  assign ch0_threshold_code = ch0_code_r;
  assign ch1_threshold_code = threshold_r[3:0];
  assign ch2_threshold_code = threshold_r[7:4];
  assign detect_on          = detect_on_r;
  assign supply_reset_req   = ch0_hold_r | (|rst_w);
  assign irq                = |(irq_status_r & irq_enable_r);
  assign ch2_passage_event  = event_r;

endmodule : svm_supply_monitor

`default_nettype wire

// ---- svm_supply_monitor_sva.sv ----
// Concurrent checks on the supply monitor ports.
`timescale 1ns/1ps
`default_nettype none
`include "svm_consts.svh"
module svm_supply_monitor_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] option_word_one,
  input wire logic       ch0_above,
  input wire logic [1:0] ch0_threshold_code,
  input wire logic [3:0] ch1_threshold_code,
  input wire logic [3:0] ch2_threshold_code,
  input wire logic [1:0] detect_on,
  input wire logic       supply_reset_req,
  input wire logic       irq,
  input wire logic       ch2_passage_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] above_cnt_r;  // Cycles of unbroken supply above the channel 0 level.
  // Counts how long comparator 0 has reported above, saturating at the top.
  always_ff @(posedge clk) begin
    if (!rst_n || !ch0_above) begin
      above_cnt_r <= 12'h000;
    end else if (above_cnt_r != 12'hFFF) begin
      above_cnt_r <= above_cnt_r + 12'h001;
    end
  end
  AST_CH0_HOLD: assert property (!ch0_above [*3] |=> supply_reset_req)
    else $error("reset request missing after supply drop");
  AST_CH0_RELEASE: assert property ($fell(supply_reset_req) |-> above_cnt_r >= 12'h7CB)
    else $error("reset released too early");
  AST_CH0_CODE: assert property ($past(rst_n) |-> ch0_threshold_code == option_word_one)
    else $error("channel 0 level code differs from option field");
  AST_THRESHOLDS: assert property (reg_wr && reg_addr == `SVM_ADDR_THRESHOLD
    |=> {ch2_threshold_code, ch1_threshold_code} == $past(reg_wdata))
    else $error("threshold codes not taken from write");
  AST_DETECT_ON: assert property (reg_wr && reg_addr == `SVM_ADDR_DETECT_EN
    |=> detect_on == $past(reg_wdata[1:0]))
    else $error("detection enables not taken from write");
  AST_IRQ_MASK: assert property (reg_wr && reg_addr == `SVM_ADDR_IRQ_ENABLE
    && reg_wdata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt high with all enables off");
  AST_EVENT_PULSE: assert property ($rose(ch2_passage_event) |=> !ch2_passage_event)
    else $error("link event longer than one cycle");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
endmodule : svm_supply_monitor_chk
bind svm_supply_monitor svm_supply_monitor_chk u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .option_word_one(option_word_one), .ch0_above(ch0_above),
  .ch0_threshold_code(ch0_threshold_code), .ch1_threshold_code(ch1_threshold_code),
  .ch2_threshold_code(ch2_threshold_code), .detect_on(detect_on),
  .supply_reset_req(supply_reset_req), .irq(irq), .ch2_passage_event(ch2_passage_event));
`default_nettype wire

// ---- svm_analog_model.sv ----
// Behavioural comparators and free-running slow oscillator beside the monitor.
`timescale 1ns/1ps
`default_nettype none
module svm_analog_model #(
  parameter int OSC_HALF_NS = 200  // Oscillator half period, a plain default.
) (
  input  wire logic [15:0] supply_mv,  // Supply level in millivolts.
  input  wire logic [1:0]  ch0_code,   // Channel 0 level select.
  input  wire logic [3:0]  ch1_code,   // Channel 1 level select.
  input  wire logic [3:0]  ch2_code,   // Channel 2 level select.
  output var logic         osc,        // Slow oscillator.
  output var logic         ch0_above,  // Supply above channel 0 level.
  output var logic         ch1_above,  // Supply above channel 1 level.
  output var logic         ch2_above   // Supply above channel 2 level.
);
  // Maps a level code to millivolts; prohibited codes give no usable level.
  function automatic logic [15:0] lvl_mv(input logic [3:0] c);
    case (c)
      4'h4: return 16'h11DA;
      4'h5: return 16'h1176;
      4'h6: return 16'h10E0;
      4'hA: return 16'h0B72;
      4'hB: return 16'h0B40;
      default: return 16'hFFFF;
    endcase
  endfunction : lvl_mv
  // The oscillator runs free, out of phase with the system clock.
  initial begin
    osc = 1'b0;
    #37;
    forever #(OSC_HALF_NS) osc = ~osc;
  end
  // Each comparator says whether the supply is above its level.
  always_comb begin
    ch0_above = supply_mv > ((ch0_code == 2'h3) ? 16'h107C : 16'h0B0E);
    ch1_above = supply_mv > lvl_mv(ch1_code);
    ch2_above = supply_mv > lvl_mv(ch2_code);
  end
endmodule : svm_analog_model
`default_nettype wire

// ---- tb_svm_supply_monitor.sv ----
// Self-checking testbench of the supply monitor control logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_svm_supply_monitor;
  import svm_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, osc, a0, a1, a2, req, irq, ev;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rdv, lfsr_r;
  logic [1:0]  opt, c0, det;
  logic [3:0]  c1, c2, k1, k2;
  logic [15:0] supply_mv;
  int          err_total, tests_run, ev_cnt, n, tk;
  logic [3:0]  codes [5] = '{4'h4, 4'h5, 4'h6, 4'hA, 4'hB};
  logic [7:0]  ra [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h0A, 8'h07, 8'h09, 8'h04, 8'h06};
  logic [7:0]  rv [10] = '{8'h00, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02};
  svm_cond_t   cond;
  svm_supply_monitor dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .option_word_one(opt),
    .slow_onchip_oscillator(osc), .ch0_above(a0), .ch1_above(a1), .ch2_above(a2),
    .ch0_threshold_code(c0), .ch1_threshold_code(c1), .ch2_threshold_code(c2),
    .detect_on(det), .supply_reset_req(req), .irq(irq), .ch2_passage_event(ev));
  svm_analog_model model (.supply_mv(supply_mv), .ch0_code(c0), .ch1_code(c1), .ch2_code(c2),
    .osc(osc), .ch0_above(a0), .ch1_above(a1), .ch2_above(a2));
  // System clock, 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts link events as they are seen on the clock.
  always @(posedge clk) if (ev === 1'b1) ev_cnt++;
  // Next value of the bench's pseudo-random sequence.
  function automatic logic [7:0] lfsr8(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr8
  // One-cycle register write; returns once the write has landed.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // One-cycle register read; data is taken in the answer cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Reads a register and compares it with the expected value.
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    rd(a, rdv);
    `CHK(rdv, e)
  endtask : chk_rd
  // Moves the supply, then lets a number of cycles pass.
  task automatic sv(input logic [15:0] mv, input int k);
    @(posedge clk);
    supply_mv <= mv;
    repeat (k) @(posedge clk);
    #1;
  endtask : sv
  // Waits, bounded, for the reset request to reach a level; k is the cycle count.
  task automatic wait_req(input logic lvl, output int k);
    k = 0;
    while (req !== lvl && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
  endtask : wait_req
  // Polls channel 1 level flag until it reads want; k is the cycle count.
  task automatic wait_lvl(input logic want, output int k);
    k = 0;
    do begin
      rd(8'h04, rdv);
      k += 2;
    end while (rdv[1] !== want && k < 1200);
  endtask : wait_lvl
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Cuts a hang short.
  initial begin
    #(40000 * 50);
    err_total++;
    summarize();
  end
  // Main sequence.
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {err_total, tests_run, ev_cnt} = '0;
    opt = 2'h2;
    supply_mv = 16'h1388;
    lfsr_r = 8'h50;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_req(1'b0, n);
    `CHK(n >= 1990 && n <= 2010, 1'b1)
    `CHK(c0, opt)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 10; i++) chk_rd(ra[i], rv[i]);
    for (int i = 0; i < 6; i++) begin
      lfsr_r = lfsr8(lfsr_r);
      wr(8'h02, lfsr_r);
      chk_rd(8'h02, lfsr_r & 8'hF7);
      k1 = codes[lfsr_r % 5];
      k2 = codes[lfsr_r[7:4] % 5];
      wr(8'h01, {k2, k1});
      `CHK({c2, c1}, {k2, k1})
    end
    wr(8'h02, 8'h00);
    wr(8'h01, 8'hA4);
    sv(16'h0AF0, 1);
    wait_req(1'b1, n);
    `CHK(n <= 5, 1'b1)
    sv(16'h1388, 0);
    wait_req(1'b0, n);
    `CHK(n >= 1990 && n <= 2010, 1'b1)
    wr(8'h02, 8'h07);
    wr(8'h0A, 8'h01);
    wr(8'h00, 8'h01);
    sv(16'h1194, 6);
    chk_rd(8'h04, 8'h01);
    `CHK(irq, 1'b1)
    sv(16'h1388, 6);
    chk_rd(8'h04, 8'h03);
    wr(8'h04, 8'h00);
    chk_rd(8'h04, 8'h02);
    chk_rd(8'h08, 8'h01);
    wr(8'h09, 8'h01);
    wr(8'h0A, 8'h00);
    sv(16'h1194, 6);
    `CHK(irq, 1'b0)
    wr(8'h0A, 8'h01);
    `CHK(irq, 1'b1)
    sv(16'h1388, 6);
    wr(8'h09, 8'h01);
    wr(8'h04, 8'h00);
    `CHK(irq, 1'b0)
    wr(8'h02, 8'h03);
    sv(16'h1194, 6);
    chk_rd(8'h04, 8'h02);
    wr(8'h02, 8'h07);
    wr(8'h00, 8'h00);
    sv(16'h1388, 6);
    chk_rd(8'h04, 8'h01);
    wr(8'h00, 8'h01);
    sv(16'h1388, 6);
    chk_rd(8'h04, 8'h03);
    wr(8'h09, 8'h03);
    wr(8'h04, 8'h00);
    wr(8'h0A, 8'h00);
    for (int m = 0; m < 3; m++) begin
      wr(8'h02, (m == 0) ? 8'hC7 : (m == 1) ? 8'h47 : 8'h46);
      sv(16'h1194, 8);
      `CHK(req, (m != 2))
      sv(16'h1388, 0);
      wait_req(1'b0, n);
      `CHK((m == 1) ? (n >= 1990 && n <= 2010) : (n <= 6), 1'b1)
    end
    chk_rd(8'h08, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h03, 8'h07);
    wr(8'h00, 8'h02);
    wr(8'h0A, 8'h02);
    for (int m = 0; m < 4; m++) begin
      cond = svm_cond_t'(m);
      wr(8'h05, {6'h00, cond});
      ev_cnt = 0;
      sv(16'h0B54, 6);
      chk_rd(8'h06, {7'h00, cond != SVM_COND_RISE});
      chk_rd(8'h08, (cond != SVM_COND_RISE) ? 8'h02 : 8'h00);
      sv(16'h1388, 6);
      chk_rd(8'h08, 8'h02);
      `CHK(ev_cnt > 0, 1'b1)
      wr(8'h06, 8'h00);
      wr(8'h09, 8'h02);
    end
    wr(8'h03, 8'h00);
    wr(8'h0A, 8'h00);
    wr(8'h00, 8'h01);
    for (int d = 0; d < 4; d++) begin
      tk = 8 << (d + 1);
      wr(8'h02, {2'h0, d[1:0], 4'h4});
      sv(16'h1194, 0);
      sv(16'h1388, 3 * tk);
      chk_rd(8'h04, 8'h02);
      sv(16'h1194, 0);
      wait_lvl(1'b0, n);
      `CHK(n >= tk - 16 && n <= 2 * tk + 24, 1'b1)
      sv(16'h1388, 0);
      wait_lvl(1'b1, n);
      wr(8'h04, 8'h00);
    end
    summarize();
  end
endmodule : tb_svm_supply_monitor
`default_nettype wire
